// ==== rtl/ipmc_defs.svh ====
// Register offsets, field positions, reset values and bus response codes of the pipe mode control
`ifndef IPMC_DEFS_SVH
`define IPMC_DEFS_SVH

`define IPMC_OFF_RUN_MODE    12'h000
`define IPMC_OFF_DATA_PATH   12'h004
`define IPMC_OFF_PHASE       12'h008
`define IPMC_OFF_ENABLE      12'h00C
`define IPMC_OFF_STATUS      12'h010
`define IPMC_OFF_AREA_LINES  12'h014

`define IPMC_BIT_SINGLE      0
`define IPMC_BIT_GATING      1
`define IPMC_BIT_BYPASS      2
`define IPMC_BIT_ENABLE      0

`define IPMC_PATH_HI         1
`define IPMC_PATH_LO         0
`define IPMC_OO_HI           7
`define IPMC_OO_LO           6
`define IPMC_OE_HI           5
`define IPMC_OE_LO           4
`define IPMC_EO_HI           3
`define IPMC_EO_LO           2
`define IPMC_EE_HI           1
`define IPMC_EE_LO           0

`define IPMC_RUN_MODE_RST    2'h0
`define IPMC_DATA_PATH_RST   3'h0
`define IPMC_PHASE_RST       8'h00
`define IPMC_AREA_RST        13'h0000
`define IPMC_ADDR_LSB        2
`define IPMC_ADDR_W          12

`define IPMC_RESP_OKAY       2'h0
`define IPMC_RESP_SLVERR     2'h2

`define IPMC_WORD_ZERO       32'h0000_0000
`define IPMC_MAX_RAW_WIDTH   13'h1000

`endif

// ==== rtl/ipmc_pkg.sv ====
// Types shared by the pipe mode control block
package ipmc_pkg;

  typedef enum logic [1:0] {
    IPMC_BAYER_TO_YCBCR,
    IPMC_BAYER_TO_BAYER,
    IPMC_BAYER_TO_BLOCK_AVG,
    IPMC_YCBCR_TO_YCBCR
  } ipmc_path_t;

  typedef enum logic [1:0] {
    IPMC_RED,
    IPMC_GREEN_ON_RED_LINE,
    IPMC_GREEN_ON_BLUE_LINE,
    IPMC_BLUE
  } ipmc_color_t;

endpackage : ipmc_pkg

// ==== rtl/ipmc_line_counter.sv ====
// Line counter that flags the end of the processing area
`timescale 1ns/1ps
`include "ipmc_defs.svh"

module ipmc_line_counter (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        frameStart,
  input  wire logic        lineStrobe,
  input  wire logic        active,
  input  wire logic [12:0] areaLines,
  output logic             areaDone
);

  logic [12:0] lineCount;

  // Counts strobes of an active frame; done pulses once the last area line passes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lineCount <= `IPMC_AREA_RST;
      areaDone  <= 1'b0;
    end else begin
      areaDone <= 1'b0;
      if (frameStart) begin
        lineCount <= `IPMC_AREA_RST;
      end else if (active && lineStrobe) begin
        if (lineCount == areaLines) begin
          areaDone  <= 1'b1;
          lineCount <= `IPMC_AREA_RST;
        end else begin
          lineCount <= lineCount + 13'h0001;
        end
      end
    end
  end

endmodule : ipmc_line_counter

// ==== rtl/ipmc_mode_ctrl.sv ====
// Contract
// [RL1] Gating off: ignore write enable, process all
// [RL2] Gating on: process only write-enabled frames
// [RL3] Software clears gating for interface-made timing
// [RL4] Single-frame bit: 0 free run, 1 single
// [RL5] Processing starts at next vertical sync rise
// [RL6] Single frame clears enable at area end
// [RL7] Bypass bit routes raw input unmodified
// [RL8] Bypass valid only for Bayer-to-Bayer path
// [RL9] Path field: four encoded input/output paths
// [RL10] Odd-line colour phases in bits 7-4
// [RL11] Even-line colour phases in bits 3-0
// [RL12] Colour codes: red, two greens, blue
// [RL13] Colour phases used only on path 0
// [RL14] Write enable sampled at frame start
`timescale 1ns/1ps
`include "ipmc_defs.svh"

module ipmc_mode_ctrl (
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // AXI4-Lite slave
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Frame timing
  input  wire logic                 vertical_sync,
  input  wire logic                 line_strobe,
  input  wire logic                 frame_write_enable_in,
  // Pipe steering
  output logic                      frame_active,
  output ipmc_pkg::ipmc_path_t      data_path_sel,
  output logic                      raw_bypass_active,
  output logic                      phase_valid,
  output ipmc_pkg::ipmc_color_t     odd_line_odd_pix_color,
  output ipmc_pkg::ipmc_color_t     odd_line_even_pix_color,
  output ipmc_pkg::ipmc_color_t     even_line_odd_pix_color,
  output ipmc_pkg::ipmc_color_t     even_line_even_pix_color
);
  import ipmc_pkg::*;

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  logic [1:0]  runMode;
  logic [2:0]  pathReg;
  logic [7:0]  phaseReg;
  logic        procEnable;
  logic [12:0] areaLines;
  logic        vsyncPrev;
  logic        vsyncRise;
  logic        areaDone;
  logic        lastFrameDone;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  logic        awHeld;
  logic        wHeld;
  logic [11:0] awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        doWrite;
  logic        wrHit;
  logic        enWrite;

  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_comb begin
    wrHit = 1'b1;
    unique case (awAddr)
      `IPMC_OFF_RUN_MODE, `IPMC_OFF_DATA_PATH, `IPMC_OFF_PHASE,
      `IPMC_OFF_ENABLE, `IPMC_OFF_STATUS, `IPMC_OFF_AREA_LINES: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  assign enWrite = doWrite && awAddr == `IPMC_OFF_ENABLE && wStrb[0];

  // Address and data are taken in either order and held until the write retires
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= 12'h000;
      wData         <= `IPMC_WORD_ZERO;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= {s_axi_awaddr[11:`IPMC_ADDR_LSB], 2'h0};
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IPMC_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? `IPMC_RESP_OKAY : `IPMC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      runMode   <= `IPMC_RUN_MODE_RST;
      pathReg   <= `IPMC_DATA_PATH_RST;
      phaseReg  <= `IPMC_PHASE_RST;
      areaLines <= `IPMC_AREA_RST;
    end else if (doWrite && wStrb[0]) begin
      unique case (awAddr)
        `IPMC_OFF_RUN_MODE:   runMode   <= wData[1:0];        // RL4 RL1
        `IPMC_OFF_DATA_PATH:  pathReg   <= wData[2:0];        // RL9 RL7
        `IPMC_OFF_PHASE:      phaseReg  <= wData[7:0];        // RL10 RL11
        `IPMC_OFF_AREA_LINES: begin
          if (wStrb[1]) begin
            areaLines <= {wData[12:8], wData[7:0]};
          end else begin
            areaLines <= {areaLines[12:8], wData[7:0]};
          end
        end
        default: ;
      endcase
    end else if (doWrite && wStrb[1] && awAddr == `IPMC_OFF_AREA_LINES) begin
      areaLines <= {wData[12:8], areaLines[7:0]};
    end
  end

  // --------------------------------------------------------------------------
  // Frame sequencing
  // --------------------------------------------------------------------------
  assign vsyncRise = vertical_sync && !vsyncPrev;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vsyncPrev <= 1'b0;
    end else begin
      vsyncPrev <= vertical_sync;
    end
  end

  ipmc_line_counter u_line_counter (
    .clk        (clk),
    .arst_n     (arst_n),
    .frameStart (vsyncRise),
    .lineStrobe (line_strobe),
    .active     (frame_active),
    .areaLines  (areaLines),
    .areaDone   (areaDone)
  );

  // End of area in single-frame mode drops enable; hardware clear beats a write
  assign lastFrameDone = areaDone && runMode[`IPMC_BIT_SINGLE];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      procEnable <= 1'b0;
    end else if (lastFrameDone) begin
      procEnable <= 1'b0;                                     // RL6
    end else if (enWrite) begin
      procEnable <= wData[`IPMC_BIT_ENABLE];
    end
  end

  // A frame starts only on a sync rise; gating samples write enable there once
  // An area end in the same cycle wins, so a single frame never restarts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_active <= 1'b0;
    end else if (vsyncRise) begin
      frame_active <= procEnable && !lastFrameDone &&         // RL5 RL6
        (!runMode[`IPMC_BIT_GATING] || frame_write_enable_in); // RL1 RL2 RL14
    end else if (lastFrameDone || !procEnable) begin
      frame_active <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Path and colour phase steering
  // --------------------------------------------------------------------------
  ipmc_path_t pathField;

  // Consumers see the codes one cycle after the register, always settled
  assign pathField = ipmc_path_t'(pathReg[`IPMC_PATH_HI:`IPMC_PATH_LO]);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_path_sel            <= IPMC_BAYER_TO_YCBCR;
      raw_bypass_active        <= 1'b0;
      phase_valid              <= 1'b0;
      odd_line_odd_pix_color   <= IPMC_RED;
      odd_line_even_pix_color  <= IPMC_RED;
      even_line_odd_pix_color  <= IPMC_RED;
      even_line_even_pix_color <= IPMC_RED;
    end else begin
      data_path_sel     <= pathField;                                    // RL9
      raw_bypass_active <= pathReg[`IPMC_BIT_BYPASS] &&
                           pathField == IPMC_BAYER_TO_BAYER;             // RL7 RL8
      phase_valid       <= pathField == IPMC_BAYER_TO_YCBCR;             // RL13
      odd_line_odd_pix_color   <= ipmc_color_t'(phaseReg[`IPMC_OO_HI:`IPMC_OO_LO]); // RL10 RL12
      odd_line_even_pix_color  <= ipmc_color_t'(phaseReg[`IPMC_OE_HI:`IPMC_OE_LO]); // RL10
      even_line_odd_pix_color  <= ipmc_color_t'(phaseReg[`IPMC_EO_HI:`IPMC_EO_LO]); // RL11
      even_line_even_pix_color <= ipmc_color_t'(phaseReg[`IPMC_EE_HI:`IPMC_EE_LO]); // RL11
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  logic [31:0] rdWord;
  logic        rdHit;

  always_comb begin
    rdWord = `IPMC_WORD_ZERO;
    rdHit  = 1'b1;
    unique case ({s_axi_araddr[11:`IPMC_ADDR_LSB], 2'h0})
      `IPMC_OFF_RUN_MODE:   rdWord = {30'h0, runMode};
      `IPMC_OFF_DATA_PATH:  rdWord = {29'h0, pathReg};
      `IPMC_OFF_PHASE:      rdWord = {24'h0, phaseReg};
      `IPMC_OFF_ENABLE:     rdWord = {31'h0, procEnable};
      `IPMC_OFF_STATUS:     rdWord = {31'h0, frame_active};
      `IPMC_OFF_AREA_LINES: rdWord = {19'h0, areaLines};
      default:              rdHit  = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `IPMC_WORD_ZERO;
      s_axi_rresp   <= `IPMC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord;
        s_axi_rresp  <= rdHit ? `IPMC_RESP_OKAY : `IPMC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_sync_rise;
    vertical_sync && !vsyncPrev;
  endsequence

  sequence s_area_end_single;
    areaDone && runMode[`IPMC_BIT_SINGLE];
  endsequence

  a_gating_off_runs: assert property (@(posedge clk) disable iff (!arst_n) // RL1
    s_sync_rise and (procEnable && !lastFrameDone && !runMode[`IPMC_BIT_GATING])
      |=> frame_active)
    else $error("frame not started with gating off");

  a_gating_skips_frame: assert property (@(posedge clk) disable iff (!arst_n) // RL2
    s_sync_rise and (runMode[`IPMC_BIT_GATING] && !frame_write_enable_in)
      |=> !frame_active)
    else $error("gated frame processed without write enable");

  a_gated_frame_runs: assert property (@(posedge clk) disable iff (!arst_n) // RL14
    s_sync_rise and (procEnable && frame_write_enable_in && !lastFrameDone)
      |=> frame_active)
    else $error("write enabled frame not started");

  a_start_on_sync: assert property (@(posedge clk) disable iff (!arst_n) // RL5
    $rose(frame_active) |-> $past(vertical_sync) && !$past(vsyncPrev))
    else $error("processing began away from sync rise");

  a_single_clears_en: assert property (@(posedge clk) disable iff (!arst_n) // RL6
    s_area_end_single |=> !procEnable && !frame_active)
    else $error("single frame did not clear enable");

  a_free_run_keeps: assert property (@(posedge clk) disable iff (!arst_n) // RL4
    procEnable && !runMode[`IPMC_BIT_SINGLE] && !enWrite |=> procEnable)
    else $error("enable dropped in free run");

  a_bypass_gated: assert property (@(posedge clk) disable iff (!arst_n) // RL8
    raw_bypass_active |-> $past(pathReg[1:0]) == 2'h1 && $past(pathReg[2]))
    else $error("bypass active outside bayer path");

  a_phase_path_zero: assert property (@(posedge clk) disable iff (!arst_n) // RL13
    phase_valid |-> data_path_sel == IPMC_BAYER_TO_YCBCR)
    else $error("colour phase valid on other path");

  a_phase_fields: assert property (@(posedge clk) disable iff (!arst_n) // RL10
    ##1 {odd_line_odd_pix_color, odd_line_even_pix_color} == $past(phaseReg[7:4]))
    else $error("odd line phase fields misplaced");

  a_even_phase_fields: assert property (@(posedge clk) disable iff (!arst_n) // RL11
    ##1 {even_line_odd_pix_color, even_line_even_pix_color} == $past(phaseReg[3:0]))
    else $error("even line phase fields misplaced");

  // A path write lands in the register, then reaches the output one cycle on
  sequence s_path_write;
    doWrite && wStrb[0] && awAddr == `IPMC_OFF_DATA_PATH;
  endsequence

  a_path_follows_write: assert property (@(posedge clk) disable iff (!arst_n) // RL9
    s_path_write |=> ##1
      data_path_sel == $past(wData[`IPMC_PATH_HI:`IPMC_PATH_LO], 2))
    else $error("data path output does not follow the written field");

  a_bypass_on: assert property (@(posedge clk) disable iff (!arst_n) // RL7
    pathReg[`IPMC_BIT_BYPASS] && pathField == IPMC_BAYER_TO_BAYER |=> raw_bypass_active)
    else $error("bypass not active on bayer path with bit set");

  a_disable_ends_frame: assert property (@(posedge clk) disable iff (!arst_n) // RL1
    !procEnable |=> !frame_active)
    else $error("frame kept running while disabled");

endmodule : ipmc_mode_ctrl

// ==== tb/test_image_pipe_mode_control.sv ====
// Self-checking bench for the pipe mode control register bank
`timescale 1ns/1ps
`include "ipmc_defs.svh"

`define CHK(nm, ex, gt) begin nChecks++; if ((gt) !== (ex)) begin numErrors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end

module test_image_pipe_mode_control;
  import ipmc_pkg::*;

  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  logic [11:0]  s_axi_awaddr = 12'h000;
  logic         s_axi_awvalid = 1'b0;
  logic         s_axi_awready;
  logic [31:0]  s_axi_wdata = 32'h0000_0000;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic         s_axi_wvalid = 1'b0;
  logic         s_axi_wready;
  logic [1:0]   s_axi_bresp;
  logic         s_axi_bvalid;
  logic         s_axi_bready = 1'b0;
  logic [11:0]  s_axi_araddr = 12'h000;
  logic         s_axi_arvalid = 1'b0;
  logic         s_axi_arready;
  logic [31:0]  s_axi_rdata;
  logic [1:0]   s_axi_rresp;
  logic         s_axi_rvalid;
  logic         s_axi_rready = 1'b0;
  logic         vertical_sync = 1'b0;
  logic         line_strobe = 1'b0;
  logic         frame_write_enable_in = 1'b0;
  logic         frame_active;
  ipmc_path_t   data_path_sel;
  logic         raw_bypass_active;
  logic         phase_valid;
  ipmc_color_t  odd_line_odd_pix_color;
  ipmc_color_t  odd_line_even_pix_color;
  ipmc_color_t  even_line_odd_pix_color;
  ipmc_color_t  even_line_even_pix_color;
  int           numErrors = 0;
  int           nChecks = 0;
  logic [7:0]   pats [2] = '{8'hE4, 8'h1B};

  ipmc_mode_ctrl uut (
    .clk, .arst_n,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready,
    .vertical_sync, .line_strobe, .frame_write_enable_in,
    .frame_active, .data_path_sel, .raw_bypass_active, .phase_valid,
    .odd_line_odd_pix_color, .odd_line_even_pix_color,
    .even_line_odd_pix_color, .even_line_even_pix_color
  );

  initial begin
    forever #50 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Bus and frame tasks
  // --------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK("bresp", er, s_axi_bresp)
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK("rdata", ed, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // Sync held three cycles so the rise is seen and the frame has started
  task automatic vs_rise;
    @(posedge clk);
    vertical_sync <= 1'b1;
    repeat (3) @(posedge clk);
    vertical_sync <= 1'b0;
    #1;
  endtask : vs_rise

  task automatic strobe(input int n);
    repeat (n) begin
      @(posedge clk);
      line_strobe <= 1'b1;
      @(posedge clk);
      line_strobe <= 1'b0;
    end
  endtask : strobe

  task automatic finish_test;
    $display("Checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------
  // Watchdog, far beyond the few hundred cycles the tests need
  // --------------------------------------------------------------
  initial begin
    #2_000_000;
    numErrors++;
    finish_test;
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) rd(12'(4 * i), 32'h0, `IPMC_RESP_OKAY);
    rd(12'h020, 32'h0, `IPMC_RESP_SLVERR);
    wr(12'h020, 32'h0000_00FF, `IPMC_RESP_SLVERR);
    wr(`IPMC_OFF_RUN_MODE, 32'h0000_00FF, `IPMC_RESP_OKAY);
    rd(`IPMC_OFF_RUN_MODE, 32'h3, `IPMC_RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      wr(`IPMC_OFF_DATA_PATH, 32'(4 + p), `IPMC_RESP_OKAY);
      settle;
      `CHK("path", ipmc_path_t'(p), data_path_sel)
      `CHK("bypass", (p == 1), raw_bypass_active)
      `CHK("phase_valid", (p == 0), phase_valid)
      rd(`IPMC_OFF_DATA_PATH, 32'(4 + p), `IPMC_RESP_OKAY);
    end
    wr(`IPMC_OFF_DATA_PATH, 32'h1, `IPMC_RESP_OKAY);
    settle;
    `CHK("bypass_off", 1'b0, raw_bypass_active)
    // Each pattern sets all four colour codes, one per field, in opposite orders
    for (int i = 0; i < 2; i++) begin
      wr(`IPMC_OFF_PHASE, {24'h0, pats[i]}, `IPMC_RESP_OKAY);
      settle;
      `CHK("oo_color", ipmc_color_t'(pats[i][7:6]), odd_line_odd_pix_color)
      `CHK("oe_color", ipmc_color_t'(pats[i][5:4]), odd_line_even_pix_color)
      `CHK("eo_color", ipmc_color_t'(pats[i][3:2]), even_line_odd_pix_color)
      `CHK("ee_color", ipmc_color_t'(pats[i][1:0]), even_line_even_pix_color)
      rd(`IPMC_OFF_PHASE, {24'h0, pats[i]}, `IPMC_RESP_OKAY);
    end
    // Lane one reaches only the upper area bits; lane zero alone keeps them
    wr(`IPMC_OFF_AREA_LINES, 32'h0000_1F05, `IPMC_RESP_OKAY);
    s_axi_wstrb <= 4'h2;
    wr(`IPMC_OFF_AREA_LINES, 32'h0000_0AFF, `IPMC_RESP_OKAY);
    rd(`IPMC_OFF_AREA_LINES, 32'h0000_0A05, `IPMC_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(`IPMC_OFF_AREA_LINES, 32'h0000_1F02, `IPMC_RESP_OKAY);
    rd(`IPMC_OFF_AREA_LINES, 32'h0000_0A02, `IPMC_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    wr(`IPMC_OFF_DATA_PATH, 32'h0, `IPMC_RESP_OKAY);
    wr(`IPMC_OFF_RUN_MODE, 32'h2, `IPMC_RESP_OKAY);
    wr(`IPMC_OFF_ENABLE, 32'h1, `IPMC_RESP_OKAY);
    settle;
    `CHK("no_sync", 1'b0, frame_active)
    vs_rise;
    `CHK("gated_skip", 1'b0, frame_active)
    @(posedge clk);
    frame_write_enable_in <= 1'b1;
    vs_rise;
    `CHK("gated_run", 1'b1, frame_active)
    @(posedge clk);
    frame_write_enable_in <= 1'b0;
    settle;
    `CHK("wen_held", 1'b1, frame_active)
    rd(`IPMC_OFF_STATUS, 32'h1, `IPMC_RESP_OKAY);
    wr(`IPMC_OFF_RUN_MODE, 32'h0, `IPMC_RESP_OKAY);
    wr(`IPMC_OFF_ENABLE, 32'h0, `IPMC_RESP_OKAY);
    settle;
    `CHK("disabled", 1'b0, frame_active)
    wr(`IPMC_OFF_ENABLE, 32'h1, `IPMC_RESP_OKAY);
    vs_rise;
    `CHK("ungated", 1'b1, frame_active)
    // Three lines per area; free run must keep the enable set
    wr(`IPMC_OFF_AREA_LINES, 32'h2, `IPMC_RESP_OKAY);
    strobe(3);
    settle;
    rd(`IPMC_OFF_ENABLE, 32'h1, `IPMC_RESP_OKAY);
    wr(`IPMC_OFF_RUN_MODE, 32'h1, `IPMC_RESP_OKAY);
    vs_rise;
    strobe(2);
    settle;
    `CHK("single_mid", 1'b1, frame_active)
    strobe(1);
    settle;
    `CHK("single_end", 1'b0, frame_active)
    rd(`IPMC_OFF_ENABLE, 32'h0, `IPMC_RESP_OKAY);
    // Mid-run reset must return the odd-line odd-pixel phase field and the phase register to red
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    settle;
    `CHK("rst_oo_color", IPMC_RED, odd_line_odd_pix_color)
    rd(`IPMC_OFF_PHASE, 32'h0, `IPMC_RESP_OKAY);
    finish_test;
  end

endmodule : test_image_pipe_mode_control
